// >>> rtl/elm_consts.svh
// Register offsets, field positions, reset values and timing counts for the
// electrode lead monitor. Assumes inclusion by bare name.
`ifndef ELM_CONSTS_SVH
`define ELM_CONSTS_SVH
// ==========================================================================
// Register byte addresses
`define ELM_IDX_STATUS 8'h01
`define ELM_IDX_CLK_CFG 8'h1A
`define ELM_IDX_ADC_THR_CTRL 8'h21
`define ELM_IDX_ADC_LO 8'h26
`define ELM_IDX_ADC_HI 8'h27
`define ELM_IDX_LOAD_LO 8'h41
`define ELM_IDX_LOAD_HI 8'h42
`define ELM_IDX_CC_CTRL 8'h50
`define ELM_IDX_CC_THR 8'h51
`define ELM_IDX_BIAS 8'h58
`define ELM_IDX_MUX 8'h60
`define ELM_IDX_IRQ_EN 8'h61
`define ELM_IDX_LIVE 8'h62
// ==========================================================================
// Field positions
`define ELM_BIT_OVER 6
`define ELM_BIT_UNDER 5
`define ELM_BIT_DRIVE_OUT_OF_RANGE_FLAG 4
`define ELM_BIT_DC_POS 1
`define ELM_BIT_DC_NEG 0
`define ELM_BIT_CLK_SEL 5
`define ELM_BIT_THR_EN 0
`define ELM_BIT_DC_EN 6
`define ELM_BIT_EXT_EN 5
`define ELM_BIT_DRV_EN 4
`define ELM_BIT_LOAD_EN 5
`define ELM_BIT_POS_BIAS 1
`define ELM_BIT_NEG_BIAS 0
// ==========================================================================
// Reset values
`define ELM_RST_BYTE 8'h00
`define ELM_RST_MUX 8'h1B
// ==========================================================================
// Persistence times in microseconds and clock rate in kHz
`define ELM_CLK_KHZ 25000
`define ELM_DC_T0_US 115000
`define ELM_DC_T1_US 140000
`define ELM_DRV_T0_US 125000
`define ELM_DRV_T1_US 128000
`define ELM_ADC_T_US 128000
`define ELM_US_TO_CYC(t) (((t) / 1000) * `ELM_CLK_KHZ)
`endif

// >>> rtl/elm_pkg.sv
// Types shared by the electrode lead monitor.
// Assumes no other package.
package elm_pkg;
  // ========================================================================
  // Electrode functions
  typedef enum logic [1:0] {
    ELM_FN_DRV_POS,
    ELM_FN_SENSE_POS,
    ELM_FN_SENSE_NEG,
    ELM_FN_DRV_NEG
  } elm_fn_t;
  // ========================================================================
  // Bus slave states
  typedef enum logic [0:0] {
    ELM_BUS_IDLE,
    ELM_BUS_DONE
  } elm_bus_t;
endpackage

// >>> rtl/elm_lead_monitor.sv
// Digital control and monitoring for a bioimpedance electrode multiplexer.
// Assumes comparator inputs are asynchronous; ADC samples are on clock_in.
// ==========================================================================
// Summary of operation
// [RL1] Each of four electrodes is routed to its programmed drive or sense function.
// [RL2] DC check enable turns on matched source and sink currents on sense inputs.
// [RL3] Three-bit field selects DC check current from 5nA to 100nA.
// [RL4] Comparators flag sense voltage above high or below low limit.
// [RL5] DC fault flag sets after unbroken violation over 115ms or 140ms.
// [RL6] Four-bit threshold field sets DC check comparator limits.
// [RL7] Software sets external check with DC enable; check then uses direct pins.
// [RL8] Drive monitor enable samples drive amplifier output against limits.
// [RL9] Drive below 0.27V or above supply minus 0.35V is out of range.
// [RL10] Drive flag sets after 125ms or 128ms, chosen by clock rate select.
// [RL11] Digital threshold monitor on ADC output is enabled by its control bit.
// [RL12] Eight-bit low and high ADC thresholds are held in two registers.
// [RL13] ADC beyond a threshold longer than 128ms sets over or under flag.
// [RL14] Two-bit field selects 50, 100 or 200 megohm sense bias.
// [RL15] Positive and negative sense bias enables act independently.
// [RL16] Low-ohm self-test load has a two-bit select and an enable.
// [RL17] High-ohm self-test load has a two-bit select and an enable.
// [RL18] Software never enables the low-power wake circuit during measurement.
// [RL19] Persistence timers restart whenever the violation clears early.
// [RL20] Fault flags hold until read and raise a request when enabled.
`timescale 1ns/1ps
`include "elm_consts.svh"
module elm_lead_monitor #(
  parameter int DC_T0_CYC = `ELM_US_TO_CYC(`ELM_DC_T0_US),
  parameter int DC_T1_CYC = `ELM_US_TO_CYC(`ELM_DC_T1_US),
  parameter int DRV_T0_CYC = `ELM_US_TO_CYC(`ELM_DRV_T0_US),
  parameter int DRV_T1_CYC = `ELM_US_TO_CYC(`ELM_DRV_T1_US),
  parameter int ADC_T_CYC = `ELM_US_TO_CYC(`ELM_ADC_T_US),
  parameter int ADC_W = 20
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Analog comparator results
  input wire logic pos_sense_high_in,
  input wire logic pos_sense_low_in,
  input wire logic neg_sense_high_in,
  input wire logic neg_sense_low_in,
  input wire logic drive_low_in,
  input wire logic drive_high_in,
  // ADC samples
  input wire logic [ADC_W-1:0] adc_data_in,
  input wire logic adc_valid_in,
  // Analog controls
  output logic [7:0] electrode_function_out,
  output logic dc_contact_check_enable_out,
  output logic [2:0] contact_check_current_sel_out,
  output logic [3:0] contact_check_limit_out,
  output logic external_contact_check_enable_out,
  output logic drive_range_monitor_enable_out,
  output logic drive_sample_hold_out,
  output logic system_clock_rate_select_out,
  output logic [1:0] bias_resistance_select_out,
  output logic pos_sense_bias_enable_out,
  output logic neg_sense_bias_enable_out,
  output logic [1:0] low_ohm_load_select_out,
  output logic low_ohm_load_enable_out,
  output logic [1:0] high_ohm_load_select_out,
  output logic high_ohm_load_enable_out,
  // Fault request
  output logic fault_irq_out
);
  // ========================================================================
  // Input synchronisers
  logic [5:0] cmp_meta;
  logic [5:0] cmp_sync;
  logic [5:0] cmp_raw;
  assign cmp_raw = {drive_high_in, drive_low_in, neg_sense_low_in, neg_sense_high_in,
    pos_sense_low_in, pos_sense_high_in};
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      cmp_meta <= 6'h00;
      cmp_sync <= 6'h00;
    end
    else
    begin
      cmp_meta <= cmp_raw;
      cmp_sync <= cmp_meta;
    end
  end

  // ========================================================================
  // Register state
  logic [7:0] mux_reg, clk_cfg, thr_ctrl, adc_lo, adc_hi, load_lo, load_hi;
  logic [7:0] cc_ctrl, cc_thr, bias, irq_en, status;
  logic [7:0] next_mux_reg, next_clk_cfg, next_thr_ctrl, next_adc_lo, next_adc_hi;
  logic [7:0] next_load_lo, next_load_hi, next_cc_ctrl, next_cc_thr, next_bias;
  logic [7:0] next_irq_en, next_status;
  logic [31:0] rdata, next_rdata;
  elm_pkg::elm_bus_t bus_st, next_bus_st;
  logic [7:0] wr_byte, rd_byte, live;
  logic wr_hit, rd_hit;
  logic [4:0] events;

  // ========================================================================
  // Persistence timers: one per flag
  logic [4:0] viol;
  logic [31:0] limit [5];
  logic [31:0] cnt [5];
  logic [31:0] next_cnt [5];
  logic adc_over_lvl, adc_under_lvl, next_over_lvl, next_under_lvl;
  logic [7:0] adc_top;
  assign adc_top = adc_data_in[ADC_W-1 -: 8];

  always_comb
  begin
    next_over_lvl = adc_over_lvl;
    next_under_lvl = adc_under_lvl;
    if (!thr_ctrl[`ELM_BIT_THR_EN])
    begin
      next_over_lvl = 1'b0;
      next_under_lvl = 1'b0;
    end
    else if (adc_valid_in)
    begin
      next_over_lvl = $signed(adc_top) > $signed(adc_hi); // [RL12]
      next_under_lvl = $signed(adc_top) < $signed(adc_lo); // [RL12]
    end
  end

  always_comb
  begin
    // Timer 0 positive sense, timer 1 negative sense
    viol[0] = cc_ctrl[`ELM_BIT_DC_EN] & (cmp_sync[0] | cmp_sync[1]); // [RL4]
    viol[1] = cc_ctrl[`ELM_BIT_DC_EN] & (cmp_sync[2] | cmp_sync[3]); // [RL4]
    viol[`ELM_BIT_DRIVE_OUT_OF_RANGE_FLAG - 2] = cc_ctrl[`ELM_BIT_DRV_EN] & (cmp_sync[4] | cmp_sync[5]); // [RL8] [RL9]
    viol[3] = adc_over_lvl; // [RL11]
    viol[4] = adc_under_lvl; // [RL11]
    limit[0] = clk_cfg[`ELM_BIT_CLK_SEL] ? 32'(DC_T1_CYC) : 32'(DC_T0_CYC); // [RL5]
    limit[1] = limit[0];
    limit[2] = clk_cfg[`ELM_BIT_CLK_SEL] ? 32'(DRV_T1_CYC) : 32'(DRV_T0_CYC); // [RL10]
    limit[3] = 32'(ADC_T_CYC); // [RL13]
    limit[4] = 32'(ADC_T_CYC);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_tmr
      always_comb
      begin
        if (!viol[gi])
          next_cnt[gi] = 32'h0000_0000; // [RL19]
        else if (cnt[gi] <= limit[gi])
          next_cnt[gi] = cnt[gi] + 32'h0000_0001;
        else
          next_cnt[gi] = cnt[gi];
      end
      always_ff @(posedge clock_in)
      begin
        if (sys_rst_in)
          cnt[gi] <= 32'h0000_0000;
        else
          cnt[gi] <= next_cnt[gi];
      end
      // Pulse once the violation has lasted longer than the interval
      assign events[gi] = viol[gi] && (cnt[gi] == limit[gi]); // [RL5] [RL10] [RL13]
    end
  endgenerate

  // ========================================================================
  // Bus decode
  always_comb
  begin
    wr_byte = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;
    wr_hit = avs_write_in && (bus_st == elm_pkg::ELM_BUS_IDLE) && avs_byteenable_in[0];
    rd_hit = avs_read_in && (bus_st == elm_pkg::ELM_BUS_IDLE);
    live = {3'h0, viol[4], viol[3], viol[2], viol[1], viol[0]};
    case (avs_address_in)
      `ELM_IDX_STATUS: rd_byte = status;
      `ELM_IDX_CLK_CFG: rd_byte = clk_cfg;
      `ELM_IDX_ADC_THR_CTRL: rd_byte = thr_ctrl;
      `ELM_IDX_ADC_LO: rd_byte = adc_lo;
      `ELM_IDX_ADC_HI: rd_byte = adc_hi;
      `ELM_IDX_LOAD_LO: rd_byte = load_lo;
      `ELM_IDX_LOAD_HI: rd_byte = load_hi;
      `ELM_IDX_CC_CTRL: rd_byte = cc_ctrl;
      `ELM_IDX_CC_THR: rd_byte = cc_thr;
      `ELM_IDX_BIAS: rd_byte = bias;
      `ELM_IDX_MUX: rd_byte = mux_reg;
      `ELM_IDX_IRQ_EN: rd_byte = irq_en;
      `ELM_IDX_LIVE: rd_byte = live;
      default: rd_byte = 8'h00;
    endcase
  end

  // ========================================================================
  // Register next values
  always_comb
  begin
    next_mux_reg = mux_reg;
    next_clk_cfg = clk_cfg;
    next_thr_ctrl = thr_ctrl;
    next_adc_lo = adc_lo;
    next_adc_hi = adc_hi;
    next_load_lo = load_lo;
    next_load_hi = load_hi;
    next_cc_ctrl = cc_ctrl;
    next_cc_thr = cc_thr;
    next_bias = bias;
    next_irq_en = irq_en;
    next_status = status;
    next_rdata = rdata;
    next_bus_st = elm_pkg::ELM_BUS_IDLE;
    if (rd_hit)
    begin
      next_rdata = {24'h00_0000, rd_byte};
      next_bus_st = elm_pkg::ELM_BUS_DONE;
      if (avs_address_in == `ELM_IDX_STATUS)
        next_status = 8'h00; // [RL20]
    end
    if (wr_hit)
    begin
      next_bus_st = elm_pkg::ELM_BUS_DONE;
      case (avs_address_in)
        `ELM_IDX_CLK_CFG: next_clk_cfg = wr_byte;
        `ELM_IDX_ADC_THR_CTRL: next_thr_ctrl = wr_byte; // [RL11]
        `ELM_IDX_ADC_LO: next_adc_lo = wr_byte; // [RL12]
        `ELM_IDX_ADC_HI: next_adc_hi = wr_byte; // [RL12]
        `ELM_IDX_LOAD_LO: next_load_lo = wr_byte; // [RL16]
        `ELM_IDX_LOAD_HI: next_load_hi = wr_byte; // [RL17]
        `ELM_IDX_CC_CTRL: next_cc_ctrl = wr_byte; // [RL2] [RL3] [RL8]
        `ELM_IDX_CC_THR: next_cc_thr = wr_byte; // [RL6]
        `ELM_IDX_BIAS: next_bias = wr_byte; // [RL14] [RL15]
        `ELM_IDX_MUX: next_mux_reg = wr_byte; // [RL1]
        `ELM_IDX_IRQ_EN: next_irq_en = wr_byte;
        default: next_bus_st = elm_pkg::ELM_BUS_DONE;
      endcase
    end
    else if (avs_write_in && bus_st == elm_pkg::ELM_BUS_IDLE)
      next_bus_st = elm_pkg::ELM_BUS_DONE;
    // Set wins over read clear
    if (events[0])
      next_status[`ELM_BIT_DC_POS] = 1'b1; // [RL5]
    if (events[1])
      next_status[`ELM_BIT_DC_NEG] = 1'b1; // [RL5]
    if (events[2])
      next_status[`ELM_BIT_DRIVE_OUT_OF_RANGE_FLAG] = 1'b1; // [RL10]
    if (events[3])
      next_status[`ELM_BIT_OVER] = 1'b1; // [RL13]
    if (events[4])
      next_status[`ELM_BIT_UNDER] = 1'b1; // [RL13]
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      mux_reg <= `ELM_RST_MUX;
      clk_cfg <= `ELM_RST_BYTE;
      thr_ctrl <= `ELM_RST_BYTE;
      adc_lo <= `ELM_RST_BYTE;
      adc_hi <= `ELM_RST_BYTE;
      load_lo <= `ELM_RST_BYTE;
      load_hi <= `ELM_RST_BYTE;
      cc_ctrl <= `ELM_RST_BYTE;
      cc_thr <= `ELM_RST_BYTE;
      bias <= `ELM_RST_BYTE;
      irq_en <= `ELM_RST_BYTE;
      status <= `ELM_RST_BYTE;
      rdata <= 32'h0000_0000;
      bus_st <= elm_pkg::ELM_BUS_IDLE;
      adc_over_lvl <= 1'b0;
      adc_under_lvl <= 1'b0;
    end
    else
    begin
      mux_reg <= next_mux_reg;
      clk_cfg <= next_clk_cfg;
      thr_ctrl <= next_thr_ctrl;
      adc_lo <= next_adc_lo;
      adc_hi <= next_adc_hi;
      load_lo <= next_load_lo;
      load_hi <= next_load_hi;
      cc_ctrl <= next_cc_ctrl;
      cc_thr <= next_cc_thr;
      bias <= next_bias;
      irq_en <= next_irq_en;
      status <= next_status;
      rdata <= next_rdata;
      bus_st <= next_bus_st;
      adc_over_lvl <= next_over_lvl;
      adc_under_lvl <= next_under_lvl;
    end
  end

  // ========================================================================
  // Registered outputs
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
      electrode_function_out <= `ELM_RST_MUX;
      dc_contact_check_enable_out <= 1'b0;
      contact_check_current_sel_out <= 3'h0;
      contact_check_limit_out <= 4'h0;
      external_contact_check_enable_out <= 1'b0;
      drive_range_monitor_enable_out <= 1'b0;
      drive_sample_hold_out <= 1'b0;
      system_clock_rate_select_out <= 1'b0;
      bias_resistance_select_out <= 2'h0;
      pos_sense_bias_enable_out <= 1'b0;
      neg_sense_bias_enable_out <= 1'b0;
      low_ohm_load_select_out <= 2'h0;
      low_ohm_load_enable_out <= 1'b0;
      high_ohm_load_select_out <= 2'h0;
      high_ohm_load_enable_out <= 1'b0;
      fault_irq_out <= 1'b0;
    end
    else
    begin
      // Low in the cycle the answer is ready
      avs_waitrequest_out <= !(next_bus_st == elm_pkg::ELM_BUS_DONE);
      avs_readdata_out <= next_rdata;
      electrode_function_out <= next_mux_reg; // [RL1]
      dc_contact_check_enable_out <= next_cc_ctrl[`ELM_BIT_DC_EN]; // [RL2]
      contact_check_current_sel_out <= next_cc_ctrl[2:0]; // [RL3]
      contact_check_limit_out <= next_cc_thr[3:0]; // [RL6]
      // External check only meaningful with the DC check on
      external_contact_check_enable_out <= next_cc_ctrl[`ELM_BIT_EXT_EN] & next_cc_ctrl[`ELM_BIT_DC_EN]; // [RL7]
      drive_range_monitor_enable_out <= next_cc_ctrl[`ELM_BIT_DRV_EN]; // [RL8]
      drive_sample_hold_out <= next_cc_ctrl[`ELM_BIT_DRV_EN]; // [RL8]
      system_clock_rate_select_out <= next_clk_cfg[`ELM_BIT_CLK_SEL];
      bias_resistance_select_out <= next_bias[3:2]; // [RL14]
      pos_sense_bias_enable_out <= next_bias[`ELM_BIT_POS_BIAS]; // [RL15]
      neg_sense_bias_enable_out <= next_bias[`ELM_BIT_NEG_BIAS]; // [RL15]
      low_ohm_load_select_out <= next_load_lo[7:6]; // [RL16]
      low_ohm_load_enable_out <= next_load_lo[`ELM_BIT_LOAD_EN]; // [RL16]
      high_ohm_load_select_out <= next_load_hi[7:6]; // [RL17]
      high_ohm_load_enable_out <= next_load_hi[`ELM_BIT_LOAD_EN]; // [RL17]
      fault_irq_out <= |(next_status & next_irq_en); // [RL20]
    end
  end
endmodule

// >>> tb/elm_chk.sv
// Port checker for the electrode lead monitor.
// Assumes a bind onto elm_lead_monitor; one clock domain.
`timescale 1ns/1ps
`include "elm_consts.svh"
module elm_chk (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register bus
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Comparators and samples
  input wire logic pos_sense_high_in,
  input wire logic pos_sense_low_in,
  input wire logic neg_sense_high_in,
  input wire logic neg_sense_low_in,
  input wire logic drive_low_in,
  input wire logic drive_high_in,
  input wire logic adc_valid_in,
  // Controls and request
  input wire logic [7:0] electrode_function_out,
  input wire logic dc_contact_check_enable_out,
  input wire logic external_contact_check_enable_out,
  input wire logic drive_range_monitor_enable_out,
  input wire logic drive_sample_hold_out,
  input wire logic [1:0] bias_resistance_select_out,
  input wire logic pos_sense_bias_enable_out,
  input wire logic neg_sense_bias_enable_out,
  input wire logic [1:0] low_ohm_load_select_out,
  input wire logic [1:0] high_ohm_load_select_out,
  input wire logic fault_irq_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  // ==========================================================================
  // Cycles since any violation input or sample
  logic [7:0] quiet;
  logic [7:0] next_quiet;
  logic req;
  logic viol;
  logic done_rd;
  assign req = avs_read_in || avs_write_in;
  assign done_rd = avs_read_in && !avs_waitrequest_out;
  assign viol = pos_sense_high_in || pos_sense_low_in || neg_sense_high_in || neg_sense_low_in ||
                drive_low_in || drive_high_in || adc_valid_in;
  always_comb
  begin
    next_quiet = quiet;
    if (sys_rst_in || viol)
      next_quiet = 8'h00;
    else if (quiet != 8'hFF)
      next_quiet = quiet + 8'h01;
  end
  always_ff @(posedge clock_in)
  begin
    quiet <= next_quiet;
  end
  // ==========================================================================
  // Assertions
  a_answer_next: assert property ($rose(req) |=> !avs_waitrequest_out)
    else $error("request not answered in the next cycle");
  a_wait_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_idle_waits: assert property (!req |=> avs_waitrequest_out)
    else $error("answer without a request");
  a_data_upper: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_ext_needs_dc: assert property (external_contact_check_enable_out |-> dc_contact_check_enable_out)
    else $error("external check without dc check enable");
  a_hold_follows: assert property (drive_sample_hold_out == drive_range_monitor_enable_out)
    else $error("sample hold differs from drive monitor enable");
  // Controls move only at the edge that takes a write
  a_ctrl_on_write: assert property (!(avs_write_in && avs_waitrequest_out) |=>
    $stable({electrode_function_out, bias_resistance_select_out, pos_sense_bias_enable_out,
    neg_sense_bias_enable_out, low_ohm_load_select_out, high_ohm_load_select_out}))
    else $error("control changed without a write");
  a_no_spurious: assert property (quiet >= 8'h0C && !avs_write_in |=> !$rose(fault_irq_out))
    else $error("fault request without a violation");
  a_read_clears: assert property (done_rd && avs_address_in == `ELM_IDX_STATUS && quiet >= 8'h0C
    |=> !fault_irq_out)
    else $error("fault request survives status read");
  a_irq_holds: assert property (fault_irq_out && !avs_read_in && !avs_write_in |=> fault_irq_out)
    else $error("fault request dropped before read");
  c_irq: cover property ($rose(fault_irq_out));
  c_ext: cover property (external_contact_check_enable_out);
  c_status: cover property (done_rd && avs_address_in == `ELM_IDX_STATUS);
endmodule
bind elm_lead_monitor elm_chk chk_u (.clock_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .pos_sense_high_in, .pos_sense_low_in, .neg_sense_high_in,
  .neg_sense_low_in, .drive_low_in, .drive_high_in, .adc_valid_in, .electrode_function_out,
  .dc_contact_check_enable_out, .external_contact_check_enable_out, .drive_range_monitor_enable_out,
  .drive_sample_hold_out, .bias_resistance_select_out, .pos_sense_bias_enable_out,
  .neg_sense_bias_enable_out, .low_ohm_load_select_out, .high_ohm_load_select_out, .fault_irq_out);

// >>> tb/elm_body_model.sv
// Electrodes and analog comparators facing the lead monitor.
// Assumes the bench picks one stimulus code at a time.
`timescale 1ns/1ps
module elm_body_model #(
  parameter int AVDD_MV = 1800,
  parameter int ADC_W = 20
) (
  // Clock and stimulus code
  input wire logic clock_in,
  input wire logic [3:0] stim_in,
  // Comparator levels
  output logic pos_high_out,
  output logic pos_low_out,
  output logic neg_high_out,
  output logic neg_low_out,
  output logic drive_low_out,
  output logic drive_high_out,
  // Sample stream
  output logic [ADC_W-1:0] adc_data_out,
  output logic adc_valid_out
);
  int drive_mv;
  logic [2:0] tail = 3'h0;
  logic adc_on;
  assign adc_on = (stim_in == 4'h7) || (stim_in == 4'h8);
  assign drive_mv = (stim_in == 4'h5) ? 100 : (stim_in == 4'h6) ? 1700 : 900;
  assign pos_high_out = stim_in == 4'h1;
  assign pos_low_out = stim_in == 4'h2;
  assign neg_high_out = stim_in == 4'h3;
  assign neg_low_out = stim_in == 4'h4;
  assign drive_low_out = drive_mv < 270;
  assign drive_high_out = drive_mv > AVDD_MV - 350;
  // In-range tail samples settle the level after an episode
  assign adc_valid_out = adc_on || (tail != 3'h0);
  assign adc_data_out = {(stim_in == 4'h7) ? 8'h20 : (stim_in == 4'h8) ? 8'hE0 : 8'h00, {(ADC_W-8){tail[0]}}};
  always_ff @(posedge clock_in)
  begin
    tail <= adc_on ? 3'h4 : (tail != 3'h0) ? tail - 3'h1 : 3'h0;
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the electrode lead monitor.
// Assumes the design, checker and body model are compiled first.
`timescale 1ns/1ps
`include "elm_consts.svh"
module tb_top;
  localparam int DC0 = 8;
  localparam int DC1 = 12;
  localparam int DR0 = 10;
  localparam int DR1 = 14;
  localparam int ADT = 9;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [3:0] stim = 4'h0;
  logic [31:0] rdata, got;
  logic [19:0] a_d;
  logic [7:0] el_fn;
  logic [7:0] irq_mask = 8'h00;
  logic [2:0] cur;
  logic [3:0] lim;
  logic [1:0] bias, lo_sel, hi_sel;
  logic wait_r, p_h, p_l, n_h, n_l, d_l, d_h, a_v, dc_en, ext_en, drv_en, s_h;
  logic clk_sel, pos_b, neg_b, lo_en, hi_en, irq;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] r_adr [11] = '{`ELM_IDX_MUX, `ELM_IDX_CC_CTRL, `ELM_IDX_CC_THR, `ELM_IDX_BIAS, `ELM_IDX_LOAD_LO,
    `ELM_IDX_LOAD_HI, `ELM_IDX_CLK_CFG, `ELM_IDX_ADC_THR_CTRL, `ELM_IDX_ADC_LO, `ELM_IDX_ADC_HI, `ELM_IDX_IRQ_EN};
  logic [7:0] r_val [11] = '{8'h4E, 8'h77, 8'h0A, 8'h09, 8'hA0, 8'h60, 8'h20, 8'h01, 8'hF0, 8'h10, 8'h73};
  logic [3:0] t_src [11] = '{4'h1, 4'h4, 4'h4, 4'h3, 4'h2, 4'h5, 4'h6, 4'h6, 4'h7, 4'h8, 4'h8};
  logic t_sel [11] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  int t_hold [11] = '{DC0+6, DC0-1, DC0+3, DC1+6, DC0+6, DR0+6, DR0+2, DR1+6, ADT+6, ADT+6, ADT-2};
  logic [7:0] t_exp [11] = '{8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 8'h10, 8'h00, 8'h10, 8'h40, 8'h20, 8'h00};
  always #20 clock_in = ~clock_in;
  elm_lead_monitor #(.DC_T0_CYC(DC0), .DC_T1_CYC(DC1), .DRV_T0_CYC(DR0), .DRV_T1_CYC(DR1), .ADC_T_CYC(ADT),
    .ADC_W(20)) dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .pos_sense_high_in(p_h), .pos_sense_low_in(p_l),
    .neg_sense_high_in(n_h), .neg_sense_low_in(n_l), .drive_low_in(d_l), .drive_high_in(d_h),
    .adc_data_in(a_d), .adc_valid_in(a_v), .electrode_function_out(el_fn), .dc_contact_check_enable_out(dc_en),
    .contact_check_current_sel_out(cur), .contact_check_limit_out(lim), .external_contact_check_enable_out(ext_en),
    .drive_range_monitor_enable_out(drv_en), .drive_sample_hold_out(s_h), .system_clock_rate_select_out(clk_sel),
    .bias_resistance_select_out(bias), .pos_sense_bias_enable_out(pos_b), .neg_sense_bias_enable_out(neg_b),
    .low_ohm_load_select_out(lo_sel), .low_ohm_load_enable_out(lo_en), .high_ohm_load_select_out(hi_sel),
    .high_ohm_load_enable_out(hi_en), .fault_irq_out(irq));
  elm_body_model #(.AVDD_MV(1800), .ADC_W(20)) body_u (.clock_in(clock_in), .stim_in(stim), .pos_high_out(p_h),
    .pos_low_out(p_l), .neg_high_out(n_h), .neg_low_out(n_l), .drive_low_out(d_l), .drive_high_out(d_h),
    .adc_data_out(a_d), .adc_valid_out(a_v));
  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {24'h00_0000, d};
    do
    begin
      @(posedge clock_in);
    end while (wait_r !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h00_0000, exp}, got);
  endtask
  task automatic episode(input logic [3:0] s, input int hold, input logic [7:0] exp);
    @(posedge clock_in);
    stim <= s;
    repeat (hold) @(posedge clock_in);
    stim <= 4'h0;
    repeat (16) @(posedge clock_in);
    chk("irq", {31'h0000_0000, (exp & irq_mask) != 8'h00}, {31'h0000_0000, irq});
    rd_chk(`ELM_IDX_STATUS, exp);
    rd_chk(`ELM_IDX_STATUS, 8'h00);
    chk("irq after read", 32'h0000_0000, {31'h0000_0000, irq});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    chk("mux out", {24'h00_0000, `ELM_RST_MUX}, {24'h00_0000, el_fn});
    chk("controls", 32'h0000_0000, {dc_en, cur, lim, ext_en, drv_en, s_h, clk_sel, bias, pos_b, neg_b,
      lo_sel, lo_en, hi_sel, hi_en, irq});
    for (int i = 0; i < 11; i++)
      rd_chk(r_adr[i], (i == 0) ? `ELM_RST_MUX : `ELM_RST_BYTE);
    rd_chk(`ELM_IDX_STATUS, `ELM_RST_BYTE);
    $display("test reset done");
    for (int i = 0; i < 11; i++)
      bus(1'b1, r_adr[i], r_val[i]);
    for (int i = 0; i < 11; i++)
      rd_chk(r_adr[i], r_val[i]);
    chk("mux out", 32'h0000_004E, {24'h00_0000, el_fn});
    chk("controls", {10'h000, 22'h3E_BE6B},
      {dc_en, cur, lim, ext_en, drv_en, s_h, clk_sel, bias, pos_b, neg_b, lo_sel, lo_en, hi_sel, hi_en});
    bus(1'b1, `ELM_IDX_BIAS, 8'h06);
    chk("bias", 32'h0000_0006, {28'h000_0000, bias, pos_b, neg_b});
    bus(1'b1, `ELM_IDX_CC_CTRL, 8'h20);
    chk("ext alone", 32'h0000_0000, {30'h0000_0000, ext_en, dc_en});
    be <= 4'h0;
    bus(1'b1, `ELM_IDX_ADC_LO, 8'h55);
    be <= 4'hF;
    rd_chk(`ELM_IDX_ADC_LO, 8'hF0);
    bus(1'b1, 8'h33, 8'hAA);
    rd_chk(8'h33, 8'h00);
    $display("test registers done");
    bus(1'b1, `ELM_IDX_CC_CTRL, 8'h53);
    irq_mask = 8'h73;
    for (int i = 0; i < 11; i++)
    begin
      bus(1'b1, `ELM_IDX_CLK_CFG, {2'b00, t_sel[i], 5'h00});
      episode(t_src[i], t_hold[i], t_exp[i]);
    end
    @(posedge clock_in);
    stim <= 4'h1;
    repeat (DC0-2) @(posedge clock_in);
    stim <= 4'h0;
    episode(4'h1, DC0-2, 8'h00);
    $display("test faults done");
    bus(1'b1, `ELM_IDX_IRQ_EN, 8'h00);
    irq_mask = 8'h00;
    episode(4'h2, DC0+6, 8'h02);
    bus(1'b1, `ELM_IDX_ADC_THR_CTRL, 8'h00);
    episode(4'h7, ADT+6, 8'h00);
    $display("test masks done");
    end_of_test();
  end
endmodule
